// File: hdl/rbm_pkg.sv
package rbm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] RBM_CMD_ADDR    = 4'h0;
  localparam logic [3:0] RBM_START_ADDR  = 4'h1;
  localparam logic [3:0] RBM_STOP_ADDR   = 4'h2;
  localparam logic [3:0] RBM_BOUND_ADDR  = 4'h3;
  localparam logic [3:0] RBM_TCR_ADDR    = 4'h4;
  localparam logic [3:0] RBM_STAT_ADDR   = 4'h7;
  localparam logic [3:0] RBM_RXCFG_ADDR  = 4'hc;
  localparam logic [3:0] RBM_CURR_ADDR   = 4'h8;
  localparam logic [3:0] RBM_MISS_ADDR   = 4'hd;
  localparam logic [3:0] RBM_RBCL_ADDR   = 4'ha;
  localparam logic [3:0] RBM_RBCH_ADDR   = 4'hb;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RBM_CMD_HALT     = 0;
  localparam int RBM_CMD_RUN      = 1;
  localparam int RBM_CMD_XMIT     = 2;
  localparam int RBM_STAT_SENT    = 1;
  localparam int RBM_STAT_TXERR   = 3;
  localparam int RBM_STAT_OVWARN  = 4;
  localparam int RBM_STAT_HALTED  = 7;
  localparam int RBM_TCR_LB_LO    = 1;
  localparam int RBM_TCR_LB_HI    = 2;
  localparam int RBM_RXCFG_BAD    = 0;
  localparam int RBM_RXCFG_RUNT   = 1;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] RBM_CMD_RST   = 8'h21;
  localparam logic [7:0] RBM_ZERO8     = 8'h00;
  localparam logic [7:0] RBM_PAGE_ONE  = 8'h01;
  localparam logic [7:0] RBM_HDR_BYTES = 8'h04;
  localparam logic [7:0] RBM_BYTE_LAST = 8'hff;
  localparam logic [1:0] RBM_LB_NORMAL = 2'h0;
  localparam logic [1:0] RBM_HDR_LAST  = 2'h3;

  // Receive state machine
  typedef enum logic [2:0] {
    RBM_IDLE,
    RBM_STORE,
    RBM_LINK,
    RBM_HDR,
    RBM_SUSPEND
  } rbm_state_t;

endpackage

// File: hdl/rbm_wr_if.sv
`timescale 1ns/1ns
// Write port of the local DMA towards buffer memory
interface rbm_wr_if;
  logic        valid;
  logic [15:0] addr;
  logic [7:0]  data;
  modport src (output valid, output addr, output data);
  modport dst (input valid, input addr, input data);
endinterface

// File: hdl/rbm_mem_port.sv
`timescale 1ns/1ns
// Registers the local DMA write onto the memory pins
module rbm_mem_port (
  input  wire logic  i_core_clk,  // Core clock
  input  wire logic  i_nrst,      // Sync reset, low
  input  wire logic  i_ce,        // Clock enable
  rbm_wr_if.dst      wr,          // Write from DMA
  output logic       o_we,        // Memory write strobe
  output logic [15:0] o_addr,     // Memory address
  output logic [7:0] o_data       // Memory data
);
  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_we   <= 1'b0;
      o_addr <= 16'h0000;
      o_data <= 8'h00;
    end else if (i_ce) begin
      o_we   <= wr.valid;
      o_addr <= wr.addr;
      o_data <= wr.data;
    end
  end
endmodule

// File: hdl/rbm_ring_mgr.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
// Behaviour
// - Full page links to next contiguous page
// - Check next page: stop first, then boundary
// - Next equals stop page: wrap to start
// - Next equals boundary: abort, never overwrite
// - Neither matches: link and keep storing
// - Overflow sets overwrite warning flag
// - Overflow abort keeps earlier packets intact
// - After overflow suspend receive until recovery
// - Halt finishes frame; host waits 1.6 ms
// - Loopback modes on transmit config D2,D1
// - Writing 22H starts device, remote DMA
// - Stopped device does not tally misses
// - Loopback keeps local receive DMA inactive
// - Accepted packet: header at first page
// - Next packet starts at stored next page
// - New packet starts four bytes into page
// - Rejected packet rewinds to current page
module rbm_ring_mgr
  import rbm_pkg::*;
(
  input  wire logic        i_core_clk,  // Core clock, 20 MHz
  input  wire logic        i_nrst,      // Sync reset, low
  input  wire logic        i_ce,        // Clock enable
  input  wire logic [3:0]  i_addr,      // Register index
  input  wire logic [7:0]  i_wdata,     // Register write data
  input  wire logic        i_wr,        // Register write strobe
  input  wire logic        i_rd,        // Register read strobe
  output logic      [7:0]  o_rdata,     // Read data, next cycle
  input  wire logic        i_rx_start,  // Frame begins (same clock)
  input  wire logic        i_rx_valid,  // Received byte valid
  input  wire logic [7:0]  i_rx_data,   // Received byte
  input  wire logic        i_rx_end,    // Frame ends
  input  wire logic        i_rx_good,   // Frame passed checks
  input  wire logic        i_rx_miss,   // Frame missed pulse
  input  wire logic [7:0]  i_rx_status, // Receive status byte
  input  wire logic        i_tx_sent,   // Packet sent pulse
  input  wire logic        i_tx_err,    // Transmit error pulse
  output logic             o_mem_we,    // Buffer memory write
  output logic      [15:0] o_mem_addr,  // Buffer memory address
  output logic      [7:0]  o_mem_data,  // Buffer memory data
  output logic             o_rx_abort,  // Reception aborted pulse
  output logic             o_rx_active  // Local receive DMA live
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  cmd_reg, cmd_next;
  logic [7:0]  ring_start_page_reg;
  logic [7:0]  ring_stop_page_reg;
  logic [7:0]  read_boundary_pointer_reg;
  logic [7:0]  tcr_reg;
  logic [7:0]  receive_config_reg;
  logic [7:0]  curr_reg, curr_next;
  logic [7:0]  interrupt_status_reg, stat_next;
  logic [7:0]  miss_reg;
  logic [7:0]  remote_count_low_reg;
  logic [7:0]  remote_count_high_reg;
  logic        ovf_hold_reg, ovf_hold_next;
  rbm_state_t  state_reg, state_next;
  logic [7:0]  page_reg, page_next;
  logic [7:0]  offs_reg, offs_next;
  logic [7:0]  next_pkt_reg, next_pkt_next;
  logic [15:0] count_reg, count_next;
  logic [1:0]  hdr_idx_reg, hdr_idx_next;
  logic        abort_next;

  rbm_wr_if wr_bus ();

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_cmd    = i_wr && (i_addr == RBM_CMD_ADDR);
  wire wr_stat   = i_wr && (i_addr == RBM_STAT_ADDR);
  wire halted    = cmd_reg[RBM_CMD_HALT];
  wire [1:0] lb  = tcr_reg[RBM_TCR_LB_HI:RBM_TCR_LB_LO];
  wire loopback  = (lb != RBM_LB_NORMAL);
  // Receive runs only when started, out of loopback, not suspended
  wire rx_enable = !halted && !loopback && !ovf_hold_reg;
  wire accept    = i_rx_good || receive_config_reg[RBM_RXCFG_BAD]
                   || receive_config_reg[RBM_RXCFG_RUNT];

  // Next page after the current one, compared as page numbers
  wire [7:0] page_inc  = page_reg + RBM_PAGE_ONE;
  wire       hit_stop  = (page_inc == ring_stop_page_reg);
  wire [7:0] page_cand = hit_stop ? ring_start_page_reg : page_inc;
  wire       hit_read_boundary_pointer = (page_cand == read_boundary_pointer_reg);
  // Page following the packet's last page, for the next packet
  wire [7:0] nxt_free  = hit_stop ? ring_start_page_reg : page_inc;

  // Header byte chosen by index
  wire [7:0] hdr_byte =
    (hdr_idx_reg == 2'h0) ? i_rx_status :
    (hdr_idx_reg == 2'h1) ? next_pkt_reg :
    (hdr_idx_reg == 2'h2) ? count_reg[7:0] : count_reg[15:8];

  wire store_byte = (state_reg == RBM_STORE) && i_rx_valid && !i_rx_end;
  wire page_full  = (offs_reg == RBM_BYTE_LAST);

  assign wr_bus.valid = store_byte || (state_reg == RBM_HDR);
  assign wr_bus.addr  = (state_reg == RBM_HDR) ?
                        {curr_reg, 6'h00, hdr_idx_reg} : {page_reg, offs_reg};
  assign wr_bus.data  = (state_reg == RBM_HDR) ? hdr_byte : i_rx_data;

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    page_next     = page_reg;
    offs_next     = offs_reg;
    next_pkt_next = next_pkt_reg;
    count_next    = count_reg;
    hdr_idx_next  = hdr_idx_reg;
    curr_next     = curr_reg;
    ovf_hold_next = ovf_hold_reg;
    abort_next    = 1'b0;
    case (state_reg)
      RBM_IDLE: begin
        if (i_rx_start && rx_enable) begin
          page_next  = curr_reg;
          offs_next  = RBM_HDR_BYTES;
          count_next = {8'h00, RBM_HDR_BYTES};
          state_next = RBM_STORE;
        end
      end
      RBM_STORE: begin
        if (i_rx_end) begin
          if (accept) begin
            next_pkt_next = nxt_free;
            hdr_idx_next  = 2'h0;
            state_next    = RBM_HDR;
          end else begin
            state_next = RBM_IDLE;             // curr kept, pages reclaimed
          end
        end else if (i_rx_valid) begin
          count_next = count_reg + 16'h0001;
          offs_next  = offs_reg + RBM_PAGE_ONE;
          if (page_full) begin
            state_next = RBM_LINK;
          end
        end
      end
      RBM_LINK: begin
        if (hit_read_boundary_pointer) begin
          abort_next    = 1'b1;                // nothing written
          ovf_hold_next = 1'b1;
          state_next    = RBM_SUSPEND;
        end else begin
          page_next  = page_cand;
          offs_next  = RBM_ZERO8;
          state_next = RBM_STORE;
        end
      end
      RBM_HDR: begin
        hdr_idx_next = hdr_idx_reg + 2'h1;
        if (hdr_idx_reg == RBM_HDR_LAST) begin
          curr_next  = next_pkt_reg;
          state_next = RBM_IDLE;
        end
      end
      RBM_SUSPEND: begin
        if (!ovf_hold_reg) begin
          state_next = RBM_IDLE;
        end
      end
      default: state_next = RBM_IDLE;
    endcase
    // Recovery: halt clears the suspension
    if (halted) begin
      ovf_hold_next = 1'b0;
    end
    if (i_wr && (i_addr == RBM_CURR_ADDR)) begin
      curr_next = i_wdata;
    end
  end

  // Status: hardware set wins over software clear by write of ones
  always_comb begin
    stat_next = interrupt_status_reg;
    if (wr_stat) begin
      stat_next = interrupt_status_reg & ~i_wdata;
    end
    stat_next[RBM_STAT_HALTED] = halted;
    if (abort_next) begin
      stat_next[RBM_STAT_OVWARN] = 1'b1;
    end
    if (i_tx_sent) begin
      stat_next[RBM_STAT_SENT] = 1'b1;
    end
    if (i_tx_err) begin
      stat_next[RBM_STAT_TXERR] = 1'b1;
    end
  end

  // Command: transmit request clears itself when the send finishes
  always_comb begin
    cmd_next = cmd_reg;
    if (wr_cmd) begin
      cmd_next = i_wdata;
    end else if (i_tx_sent || i_tx_err) begin
      cmd_next[RBM_CMD_XMIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_reg    <= RBM_IDLE;
      page_reg     <= RBM_ZERO8;
      offs_reg     <= RBM_ZERO8;
      next_pkt_reg <= RBM_ZERO8;
      count_reg    <= 16'h0000;
      hdr_idx_reg  <= 2'h0;
      curr_reg     <= RBM_ZERO8;
      ovf_hold_reg <= 1'b0;
      o_rx_abort   <= 1'b0;
    end else if (i_ce) begin
      state_reg    <= state_next;
      page_reg     <= page_next;
      offs_reg     <= offs_next;
      next_pkt_reg <= next_pkt_next;
      count_reg    <= count_next;
      hdr_idx_reg  <= hdr_idx_next;
      curr_reg     <= curr_next;
      ovf_hold_reg <= ovf_hold_next;
      o_rx_abort   <= abort_next;
    end
  end

  // Software registers
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      cmd_reg                   <= RBM_CMD_RST;
      ring_start_page_reg       <= RBM_ZERO8;
      ring_stop_page_reg        <= RBM_ZERO8;
      read_boundary_pointer_reg <= RBM_ZERO8;
      tcr_reg                   <= RBM_ZERO8;
      receive_config_reg        <= RBM_ZERO8;
      interrupt_status_reg      <= RBM_ZERO8;
      remote_count_low_reg      <= RBM_ZERO8;
      remote_count_high_reg     <= RBM_ZERO8;
    end else if (i_ce) begin
      cmd_reg              <= cmd_next;
      interrupt_status_reg <= stat_next;
      if (i_wr) begin
        case (i_addr)
          RBM_START_ADDR:  ring_start_page_reg       <= i_wdata;
          RBM_STOP_ADDR:   ring_stop_page_reg        <= i_wdata;
          RBM_BOUND_ADDR:  read_boundary_pointer_reg <= i_wdata;
          RBM_TCR_ADDR:    tcr_reg                   <= i_wdata;
          RBM_RXCFG_ADDR:  receive_config_reg        <= i_wdata;
          RBM_RBCL_ADDR:   remote_count_low_reg      <= i_wdata;
          RBM_RBCH_ADDR:   remote_count_high_reg     <= i_wdata;
          default: ;
        endcase
      end
    end
  end

  // Missed packet tally, frozen while halted; read clears it
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      miss_reg <= RBM_ZERO8;
    end else if (i_ce) begin
      if (i_rx_miss && !halted && (miss_reg != RBM_BYTE_LAST)) begin
        miss_reg <= miss_reg + RBM_PAGE_ONE;
      end else if (i_rd && (i_addr == RBM_MISS_ADDR)) begin
        miss_reg <= RBM_ZERO8;
      end
    end
  end

  // Read data and activity flag
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_rdata     <= RBM_ZERO8;
      o_rx_active <= 1'b0;
    end else if (i_ce) begin
      o_rx_active <= rx_enable;
      if (i_rd) begin
        case (i_addr)
          RBM_CMD_ADDR:    o_rdata <= cmd_reg;
          RBM_START_ADDR:  o_rdata <= ring_start_page_reg;
          RBM_STOP_ADDR:   o_rdata <= ring_stop_page_reg;
          RBM_BOUND_ADDR:  o_rdata <= read_boundary_pointer_reg;
          RBM_TCR_ADDR:    o_rdata <= tcr_reg;
          RBM_STAT_ADDR:   o_rdata <= interrupt_status_reg;
          RBM_CURR_ADDR:   o_rdata <= curr_reg;
          RBM_RXCFG_ADDR:  o_rdata <= receive_config_reg;
          RBM_MISS_ADDR:   o_rdata <= miss_reg;
          RBM_RBCL_ADDR:   o_rdata <= remote_count_low_reg;
          RBM_RBCH_ADDR:   o_rdata <= remote_count_high_reg;
          default:         o_rdata <= RBM_ZERO8;
        endcase
      end else begin
        o_rdata <= RBM_ZERO8;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  rbm_mem_port u_mem (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .wr         (wr_bus),
    .o_we       (o_mem_we),
    .o_addr     (o_mem_addr),
    .o_data     (o_mem_data)
  );

endmodule

// File: verif/rbm_ring_props.sv
`timescale 1ns/1ns
module rbm_ring_props
  import rbm_pkg::*;
(
  input wire logic        i_core_clk,  // Clock
  input wire logic        i_nrst,      // Reset, low
  input wire logic [3:0]  i_addr,      // Reg index
  input wire logic [7:0]  i_wdata,     // Reg data
  input wire logic        i_wr,        // Reg write
  input wire logic        i_rd,        // Reg read
  input wire logic        i_rx_end,    // Frame end
  input wire logic        i_rx_good,   // Frame good
  input wire logic [7:0]  o_rdata,     // Read data
  input wire logic        o_mem_we,    // Mem write
  input wire logic [15:0] o_mem_addr,  // Mem address
  input wire logic        o_rx_abort,  // Abort pulse
  input wire logic        o_rx_active  // DMA live
);
  logic [7:0]  start_q, stop_q, bnd_q;
  logic        acc_q;
  logic [15:0] prev_q;
  wire  [7:0]  pg = o_mem_addr[15:8];

  // ----------------------------------------------------------------
  // Shadow of ring setup
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      start_q <= 8'h00;
      stop_q  <= 8'h00;
      bnd_q   <= 8'h00;
      acc_q   <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == RBM_START_ADDR) start_q <= i_wdata;
      if (i_addr == RBM_STOP_ADDR) stop_q <= i_wdata;
      if (i_addr == RBM_BOUND_ADDR) bnd_q <= i_wdata;
      if (i_addr == RBM_RXCFG_ADDR) acc_q <= |i_wdata[1:0];
    end
  end

  // Last memory address written
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) prev_q <= 16'h0000;
    else if (o_mem_we) prev_q <= o_mem_addr;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_good_end;
    i_rx_end && i_rx_good && o_rx_active;
  endsequence
  sequence s_hdr;
    o_mem_we && o_mem_addr[7:0] == 8'h00 ##1 o_mem_we && o_mem_addr[7:0] == 8'h01
    ##1 o_mem_we && o_mem_addr[7:0] == 8'h02 ##1 o_mem_we && o_mem_addr[7:0] == 8'h03;
  endsequence

  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not idle");
  a_abort_single: assert property (o_rx_abort |=> !o_rx_abort)
    else $error("abort longer than one cycle");
  a_abort_halt: assert property (o_rx_abort |-> ##[1:2] !o_rx_active)
    else $error("receive still live after abort");
  a_stop_skip: assert property (o_mem_we |-> pg != stop_q)
    else $error("write to stop page");
  a_ring_bound: assert property (o_mem_we |-> pg >= start_q && pg < stop_q)
    else $error("write outside ring");
  a_read_boundary_pointer_guard: assert property (o_mem_we |-> pg != bnd_q)
    else $error("write to boundary page");
  a_page_link: assert property (o_mem_we && prev_q[7:0] == 8'hff && o_mem_addr[7:0] == 8'h00
    |-> pg == prev_q[15:8] + 8'h01 || pg == start_q)
    else $error("page link not contiguous");
  a_hdr_write: assert property (s_good_end |-> ##[1:4] s_hdr)
    else $error("header not written");
  a_rej_quiet: assert property (i_rx_end && !i_rx_good && !acc_q |-> ##3 !o_mem_we [*4])
    else $error("write after rejected frame");
endmodule

bind rbm_ring_mgr rbm_ring_props rbm_ring_props_inst (.i_core_clk, .i_nrst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .i_rx_end, .i_rx_good, .o_rdata, .o_mem_we, .o_mem_addr,
  .o_rx_abort, .o_rx_active);

// File: verif/rbm_mem_model.sv
`timescale 1ns/1ns
// Buffer memory behind the local DMA
module rbm_mem_model (
  input wire logic        i_core_clk,  // Clock
  input wire logic        i_we,        // Write strobe
  input wire logic [15:0] i_addr,      // Address
  input wire logic [7:0]  i_data       // Data
);
  logic [7:0] mem [0:65535];
  int         n_wr = 0;
  // Store each strobed byte
  always @(posedge i_core_clk) begin
    if (i_we === 1'b1) begin
      mem[i_addr] <= i_data;
      n_wr++;
    end
  end
endmodule

// File: verif/test_rbm_ring_mgr.sv
`timescale 1ns/1ns
module test_rbm_ring_mgr;
  import rbm_pkg::*;
  logic i_core_clk = 0, i_nrst = 0, i_ce = 1, i_wr = 0, i_rd = 0, i_rx_start = 0;
  logic i_rx_valid = 0, i_rx_end = 0, i_rx_good = 0, i_rx_miss = 0, i_tx_sent = 0;
  logic i_tx_err = 0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00, i_rx_data = 8'h00, i_rx_status = 8'h00, o_rdata, o_mem_data;
  logic [15:0] o_mem_addr;
  logic        o_mem_we, o_rx_abort, o_rx_active;
  int          err_count = 0, total_checks = 0, cyc = 0, n_abort = 0, nw;
  bit          resend;
  logic [7:0]  exp_q [logic [15:0]];
  logic [7:0]  start_p = 8'h10, stop_p = 8'h14, bnd_p = 8'h11, cur_p = 8'h12;

  rbm_ring_mgr rbm_ring_mgr_inst (.i_core_clk, .i_nrst, .i_ce, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_rx_start, .i_rx_valid, .i_rx_data, .i_rx_end, .i_rx_good,
    .i_rx_miss, .i_rx_status, .i_tx_sent, .i_tx_err, .o_mem_we, .o_mem_addr,
    .o_mem_data, .o_rx_abort, .o_rx_active);
  rbm_mem_model rbm_mem_model_inst (.i_core_clk, .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_data(o_mem_data));

  // ----------------------------------------------------------------
  // Clock, timeout, abort tally
  // ----------------------------------------------------------------
  always #25 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (o_rx_abort === 1'b1) n_abort++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(string what, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge i_core_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_core_clk) i_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge i_core_clk) {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_core_clk) i_rd <= 1'b0;
    #10 cmp("rdata", {8'h00, e}, {8'h00, o_rdata});
  endtask

  // Pulse a miss (which 0) or a sent event (which 1) k times
  task automatic pulse(int which, int k);
    repeat (k) begin
      @(posedge i_core_clk);
      if (which == 0) begin
        i_rx_miss <= 1'b1;
      end else begin
        i_tx_sent <= 1'b1;
      end
      @(posedge i_core_clk);
      i_rx_miss <= 1'b0;
      i_tx_sent <= 1'b0;
    end
  endtask

  // Drive a frame and predict what lands in memory
  task automatic frame(int n, bit good, bit take);
    logic [7:0] pg, off, d, st;
    bit live;
    logic [15:0] cnt;
    pg = cur_p;
    off = RBM_HDR_BYTES;
    live = take;
    cnt = 16'(n) + 16'h0004;
    st = 8'($urandom);
    @(posedge i_core_clk) i_rx_start <= 1'b1;
    @(posedge i_core_clk) i_rx_start <= 1'b0;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      {i_rx_valid, i_rx_data} <= {1'b1, d};
      if (live) begin
        exp_q[{pg, off}] = d;
        off++;
        if (off == 8'h00) begin
          pg++;
          if (pg == stop_p) pg = start_p;
          if (pg == bnd_p) live = 0;
        end
      end
      @(posedge i_core_clk) i_rx_valid <= 1'b0;
      repeat (2) @(posedge i_core_clk);
    end
    {i_rx_end, i_rx_good, i_rx_status} <= {1'b1, good, st};
    @(posedge i_core_clk) i_rx_end <= 1'b0;
    repeat (12) @(posedge i_core_clk);
    if (live && good) begin
      pg++;
      if (pg == stop_p) pg = start_p;
      exp_q[{cur_p, 8'h00}] = st;
      exp_q[{cur_p, 8'h01}] = pg;
      exp_q[{cur_p, 8'h02}] = cnt[7:0];
      exp_q[{cur_p, 8'h03}] = cnt[15:8];
      cur_p = pg;
    end
  endtask

  task automatic mem_chk();
    foreach (exp_q[a]) cmp("mem", {8'h00, exp_q[a]}, {8'h00, rbm_mem_model_inst.mem[a]});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(49));
    repeat (16) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    rd(RBM_CMD_ADDR, RBM_CMD_RST);
    rd(RBM_STAT_ADDR, 8'h80);
    wr(RBM_CMD_ADDR, 8'h21);
    wr(RBM_RXCFG_ADDR, 8'h00);
    wr(RBM_TCR_ADDR, 8'h04);
    wr(RBM_START_ADDR, start_p);
    wr(RBM_STOP_ADDR, stop_p);
    wr(RBM_BOUND_ADDR, bnd_p);
    wr(RBM_STAT_ADDR, 8'hff);
    wr(RBM_CMD_ADDR, 8'h61);
    wr(RBM_CURR_ADDR, cur_p);
    wr(RBM_CMD_ADDR, 8'h22);
    frame(8, 0, 0);
    cmp("loopback writes", 16'h0000, 16'(rbm_mem_model_inst.n_wr));
    wr(RBM_TCR_ADDR, 8'h00);
    pulse(0, 3);
    rd(RBM_MISS_ADDR, 8'h03);
    frame(528, 1, 1);
    mem_chk();
    rd(RBM_CURR_ADDR, 8'h11);
    bnd_p = 8'h12;
    wr(RBM_BOUND_ADDR, bnd_p);
    pulse(1, 1);
    frame(400, 1, 1);
    cmp("abort count", 16'h0001, 16'(n_abort));
    nw = rbm_mem_model_inst.n_wr;
    frame(6, 0, 0);
    cmp("suspended writes", 16'(nw), 16'(rbm_mem_model_inst.n_wr));
    mem_chk();
    rd(RBM_CMD_ADDR, 8'h22);
    wr(RBM_CMD_ADDR, 8'h21);
    pulse(0, 2);
    rd(RBM_MISS_ADDR, 8'h00);
    rd(RBM_STAT_ADDR, 8'h92);
    resend = 1'b0; // saved transmit bit was 0
    wr(RBM_RBCL_ADDR, 8'h00);
    wr(RBM_RBCH_ADDR, 8'h00);
    wr(RBM_TCR_ADDR, 8'h02);
    wr(RBM_CMD_ADDR, 8'h22);
    wr(RBM_STAT_ADDR, 8'h10);
    wr(RBM_TCR_ADDR, 8'h00);
    if (resend) begin
      wr(RBM_CMD_ADDR, 8'h26);
    end
    rd(RBM_STAT_ADDR, 8'h02);
    rd(RBM_CURR_ADDR, 8'h11);
    frame(20 + int'($urandom % 30), 0, 1);
    rd(RBM_CURR_ADDR, 8'h11);
    frame(10 + int'($urandom % 30), 1, 1);
    mem_chk();
    rd(RBM_CURR_ADDR, cur_p);
    end_sim();
  end
endmodule
